// file: design/ccoc_bank.sv
// clamp, coast, output control and sync activity register bank
`timescale 1ns/1ps
`default_nettype none
module ccoc_bank
  import ccoc_pkg::*;
#(
  parameter int ACT_WINDOW = ACT_WINDOW_CYC
)(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       hsync_in,
  input  wire logic       vsync_in,
  input  wire logic       green_embedded_sync,
  input  wire logic       dig_clk_in,
  input  wire logic       iface_override,
  input  wire logic       iface_select,
  output logic            clamp_mid_green,
  output logic            clamp_mid_blue,
  output logic            coast_out,
  output logic      [1:0] drive_strength,
  output logic            bw_high,
  output logic            dig_clk_invert,
  output logic            pixel_data_outputs_oe,
  output logic      [1:0] protect_addr,
  output logic            power_up,
  output logic            mode_422,
  output logic            active_iface
);

  ccoc_clamp_coast_t clamp_coast;
  ccoc_out_fmt_t     out_fmt;
  logic [7:0]        precoast_line_count;
  logic [7:0]        postcoast_line_count;
  logic [7:0]        sync_activity_status;
  logic [NUM_ACT-1:0] act_in;
  logic [NUM_ACT-1:0] act_prev;
  logic [NUM_ACT-1:0] act_seen;
  logic              hsync_edge;
  logic              vsync_edge;
  logic              coast_active;
  logic              coast_high;
  ccoc_iface_t       iface;
  ccoc_iface_t       next_iface;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // coast select reset one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clamp_coast <= ccoc_clamp_coast_t'(RST_CLAMP_COAST[5:1]);
    end else if (reg_wr && reg_addr == ADDR_CLAMP_COAST) begin
      clamp_coast <= ccoc_clamp_coast_t'(reg_wdata[5:1]);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      precoast_line_count <= RST_PRECOAST;
    end else if (reg_wr && reg_addr == ADDR_PRECOAST) begin
      precoast_line_count <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      postcoast_line_count <= RST_POSTCOAST;
    end else if (reg_wr && reg_addr == ADDR_POSTCOAST) begin
      postcoast_line_count <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_fmt <= ccoc_out_fmt_t'(RST_OUT_POWER_FMT);
    end else if (reg_wr && reg_addr == ADDR_OUT_POWER_FMT) begin
      out_fmt <= ccoc_out_fmt_t'(reg_wdata);
    end
  end

  // ---------------------------------------------------------------
  // activity detection
  // ---------------------------------------------------------------
  assign act_in[ACT_HSYNC]  = hsync_in;
  assign act_in[ACT_GREEN]  = green_embedded_sync;
  assign act_in[ACT_VSYNC]  = vsync_in;
  assign act_in[ACT_DIGCLK] = dig_clk_in;

  // a source counts as active while it toggled within the window;
  // a stuck-high or stuck-low line reads as absent
  generate
    for (genvar i = 0; i < NUM_ACT; i++) begin : g_act
      logic [ACT_CNT_W-1:0] quiet;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          act_prev[i] <= 1'b0;
          quiet       <= '0;
          act_seen[i] <= 1'b0;
        end else begin
          act_prev[i] <= act_in[i];
          if (act_in[i] != act_prev[i]) begin
            quiet       <= '0;
            act_seen[i] <= 1'b1;
          end else if (quiet >= ACT_CNT_W'(ACT_WINDOW - 1)) begin
            act_seen[i] <= 1'b0;
          end else begin
            quiet <= quiet + ACT_CNT_W'(1);
          end
        end
      end
    end
  endgenerate

  assign hsync_edge = act_in[ACT_HSYNC] && !act_prev[ACT_HSYNC];
  assign vsync_edge = act_in[ACT_VSYNC] && !act_prev[ACT_VSYNC];

  // ---------------------------------------------------------------
  // active interface choice
  // ---------------------------------------------------------------
  // user select gating
  always_comb begin
    next_iface = CCOC_IFACE_ANALOG;
    if (iface_override || (act_seen[ACT_DIGCLK] && (act_seen[ACT_HSYNC] || act_seen[ACT_GREEN]))) begin
      next_iface = iface_select ? CCOC_IFACE_DIGITAL : CCOC_IFACE_ANALOG;
    end else if (act_seen[ACT_DIGCLK]) begin
      next_iface = CCOC_IFACE_DIGITAL;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      iface <= CCOC_IFACE_ANALOG;
    end else begin
      iface <= next_iface;
    end
  end

  // ---------------------------------------------------------------
  // coast generation
  // ---------------------------------------------------------------
  // coast only when selected
  ccoc_coast_timer u_coast (
    .clock        (clock),
    .rst_n        (rst_n),
    .enable       (clamp_coast.coast_sel),
    .hsync_edge   (hsync_edge),
    .vsync_edge   (vsync_edge),
    .precoast     (precoast_line_count),
    .postcoast    (postcoast_line_count),
    .coast_active (coast_active)
  );

  assign coast_high = clamp_coast.coast_ovr ? clamp_coast.coast_pol : AUTO_COAST_ACTIVE_HIGH;

  // disabled coast idles at the inverse of its active level, low under auto polarity
  // with override and polarity both one, an idle active-high coast sits low,
  // which is the documented way software parks the coast line
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      coast_out <= ~AUTO_COAST_ACTIVE_HIGH;
    end else begin
      coast_out <= coast_active ? coast_high : ~coast_high;
    end
  end

  // ---------------------------------------------------------------
  // control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clamp_mid_green <= RST_CLAMP_COAST[BIT_GREEN_MID];
      clamp_mid_blue  <= RST_CLAMP_COAST[BIT_BLUE_MID];
    end else begin
      clamp_mid_green <= clamp_coast.green_mid;
      clamp_mid_blue  <= clamp_coast.blue_mid;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drive_strength <= RST_OUT_POWER_FMT[BIT_DRIVE_HI:BIT_DRIVE_LO];
      bw_high        <= RST_OUT_POWER_FMT[BIT_BW_HIGH];
      dig_clk_invert <= RST_OUT_POWER_FMT[BIT_CLK_INV];
      protect_addr   <= {PROT_ADDR1, RST_OUT_POWER_FMT[BIT_PROT_ADDR0]};
      power_up       <= RST_OUT_POWER_FMT[BIT_POWER_UP];
      mode_422       <= RST_OUT_POWER_FMT[BIT_MODE_422];
    end else begin
      drive_strength <= out_fmt.drive;
      bw_high        <= out_fmt.bw_high;
      dig_clk_invert <= out_fmt.clk_inv;
      protect_addr   <= {PROT_ADDR1, out_fmt.prot_addr0};
      power_up       <= out_fmt.power_up;
      mode_422       <= out_fmt.mode_422;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pixel_data_outputs_oe <= 1'b1;
    end else begin
      pixel_data_outputs_oe <= !(out_fmt.tristate && next_iface == CCOC_IFACE_DIGITAL);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_iface <= 1'b0;
    end else begin
      active_iface <= (next_iface == CCOC_IFACE_DIGITAL);
    end
  end

  // ---------------------------------------------------------------
  // status and read data
  // ---------------------------------------------------------------
  always_comb begin
    sync_activity_status = 8'h00;
    sync_activity_status[BIT_ST_HSYNC]  = act_seen[ACT_HSYNC];
    sync_activity_status[BIT_ST_VSYNC]  = act_seen[ACT_VSYNC];
    sync_activity_status[BIT_ST_GREEN]  = act_seen[ACT_GREEN];
    sync_activity_status[BIT_ST_DIGCLK] = act_seen[ACT_DIGCLK];
    sync_activity_status[BIT_ST_IFACE]  = (iface == CCOC_IFACE_DIGITAL);
  end

  // live status read
  // status has no write path; a write to its offset falls through every decode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CLAMP_COAST:   reg_rdata <= {2'b00, clamp_coast, 1'b0};
        ADDR_PRECOAST:      reg_rdata <= precoast_line_count;
        ADDR_POSTCOAST:     reg_rdata <= postcoast_line_count;
        ADDR_OUT_POWER_FMT: reg_rdata <= out_fmt;
        ADDR_SYNC_STATUS:   reg_rdata <= sync_activity_status;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: design/ccoc_coast_timer.sv
// line counter that opens the coast window before vsync and holds it after
`timescale 1ns/1ps
`default_nettype none
module ccoc_coast_timer
  import ccoc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       hsync_edge,
  input  wire logic       vsync_edge,
  input  wire logic [7:0] precoast,
  input  wire logic [7:0] postcoast,
  output logic            coast_active
);

  logic [11:0] line_cnt;
  logic [11:0] frame_lines;
  logic [7:0]  post_left;
  logic [11:0] lines_left;

  // ---------------------------------------------------------------
  // frame length learning
  // ---------------------------------------------------------------
  // the previous frame length predicts where the next vsync falls
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_cnt    <= 12'h000;
      frame_lines <= 12'h000;
    end else if (vsync_edge) begin
      frame_lines <= line_cnt;
      line_cnt    <= 12'h000;
    end else if (hsync_edge && line_cnt != 12'hfff) begin
      line_cnt <= line_cnt + 12'h001;
    end
  end

  assign lines_left = (frame_lines > line_cnt) ? (frame_lines - line_cnt) : 12'h000;

  // ---------------------------------------------------------------
  // postcoast hold
  // ---------------------------------------------------------------
  // hold after vsync
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      post_left <= 8'h00;
    end else if (vsync_edge) begin
      post_left <= postcoast;
    end else if (hsync_edge && post_left != 8'h00) begin
      post_left <= post_left - 8'h01;
    end
  end

  // open before vsync
  // lines_left counts hsyncs still due before vsync, one less than the periods left, so a strict compare
  // opens the window exactly precoast periods ahead
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      coast_active <= 1'b0;
    end else begin
      coast_active <= enable && ((post_left != 8'h00) ||
                      (precoast != 8'h00 && frame_lines != 12'h000 &&
                       lines_left < {4'h0, precoast}));
    end
  end

endmodule
`default_nettype wire

// file: design/ccoc_pkg.sv
// constants and types shared by the clamp, coast and output control bank
package ccoc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CLAMP_COAST   = 8'h11;
  localparam logic [7:0] ADDR_PRECOAST      = 8'h12;
  localparam logic [7:0] ADDR_POSTCOAST     = 8'h13;
  localparam logic [7:0] ADDR_OUT_POWER_FMT = 8'h14;
  localparam logic [7:0] ADDR_SYNC_STATUS   = 8'h15;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_GREEN_MID  = 5;
  localparam int BIT_BLUE_MID   = 4;
  localparam int BIT_COAST_SEL  = 3;
  localparam int BIT_COAST_OVR  = 2;
  localparam int BIT_COAST_POL  = 1;
  localparam int BIT_DRIVE_HI   = 7;
  localparam int BIT_DRIVE_LO   = 6;
  localparam int BIT_BW_HIGH    = 5;
  localparam int BIT_CLK_INV    = 4;
  localparam int BIT_TRISTATE   = 3;
  localparam int BIT_PROT_ADDR0 = 2;
  localparam int BIT_POWER_UP   = 1;
  localparam int BIT_MODE_422   = 0;
  localparam int BIT_ST_HSYNC   = 7;
  localparam int BIT_ST_GREEN   = 6;
  localparam int BIT_ST_VSYNC   = 5;
  localparam int BIT_ST_DIGCLK  = 4;
  localparam int BIT_ST_IFACE   = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CLAMP_COAST   = 8'h0a;
  localparam logic [7:0] RST_PRECOAST      = 8'h00;
  localparam logic [7:0] RST_POSTCOAST     = 8'h00;
  localparam logic [7:0] RST_OUT_POWER_FMT = 8'he2;
  localparam logic       PROT_ADDR1        = 1'b1;
  // polarity used while the chip chooses for itself
  localparam logic       AUTO_COAST_ACTIVE_HIGH = 1'b1;

  // ---------------------------------------------------------------
  // activity detection timing
  // ---------------------------------------------------------------
  localparam int CLOCK_KHZ        = 10_000;
  localparam int ACT_WINDOW_MS    = 50;
  localparam int ACT_WINDOW_CYC   = ACT_WINDOW_MS * CLOCK_KHZ;
  localparam int ACT_CNT_W        = 20;
  localparam int NUM_ACT          = 4;
  localparam int ACT_HSYNC        = 0;
  localparam int ACT_GREEN        = 1;
  localparam int ACT_VSYNC        = 2;
  localparam int ACT_DIGCLK       = 3;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic green_mid;
    logic blue_mid;
    logic coast_sel;
    logic coast_ovr;
    logic coast_pol;
  } ccoc_clamp_coast_t;

  typedef struct packed {
    logic [1:0] drive;
    logic       bw_high;
    logic       clk_inv;
    logic       tristate;
    logic       prot_addr0;
    logic       power_up;
    logic       mode_422;
  } ccoc_out_fmt_t;

  typedef enum logic {CCOC_IFACE_ANALOG, CCOC_IFACE_DIGITAL} ccoc_iface_t;

endpackage

// file: sim/ccoc_bank_sva.sv
// assertion checker for the clamp, coast and output control bank
`timescale 1ns/1ps
`default_nettype none
module ccoc_bank_sva
  import ccoc_pkg::*;
#(
  parameter int ACT_WINDOW = ACT_WINDOW_CYC
)(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       clamp_mid_green,
  input wire logic       clamp_mid_blue,
  input wire logic       coast_out,
  input wire logic [1:0] drive_strength,
  input wire logic       bw_high,
  input wire logic       dig_clk_invert,
  input wire logic       pixel_data_outputs_oe,
  input wire logic [1:0] protect_addr,
  input wire logic       power_up,
  input wire logic       active_iface
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // -------------------------------------------------------------
  // control outputs follow writes two edges on
  // -------------------------------------------------------------
  a_green_clamp_follows: assert property (reg_wr && reg_addr == ADDR_CLAMP_COAST |-> ##2
    clamp_mid_green == $past(reg_wdata[BIT_GREEN_MID], 2)) else $error("green clamp wrong");
  a_blue_clamp_follows: assert property (reg_wr && reg_addr == ADDR_CLAMP_COAST |-> ##2
    clamp_mid_blue == $past(reg_wdata[BIT_BLUE_MID], 2)) else $error("blue clamp wrong");
  a_drive_follows: assert property (reg_wr && reg_addr == ADDR_OUT_POWER_FMT |-> ##2
    drive_strength == $past(reg_wdata[7:6], 2)) else $error("drive strength wrong");
  a_bw_follows: assert property (reg_wr && reg_addr == ADDR_OUT_POWER_FMT |-> ##2
    bw_high == $past(reg_wdata[BIT_BW_HIGH], 2)) else $error("bandwidth wrong");
  a_clkinv_follows: assert property (reg_wr && reg_addr == ADDR_OUT_POWER_FMT |-> ##2
    dig_clk_invert == $past(reg_wdata[BIT_CLK_INV], 2)) else $error("clock invert wrong");
  a_power_follows: assert property (reg_wr && reg_addr == ADDR_OUT_POWER_FMT |-> ##2
    power_up == $past(reg_wdata[BIT_POWER_UP], 2)) else $error("power state wrong");
  a_prot_addr_fixed: assert property (reg_wr && reg_addr == ADDR_OUT_POWER_FMT |-> ##2
    protect_addr == {1'b1, $past(reg_wdata[BIT_PROT_ADDR0], 2)}) else $error("protect address wrong");
  // three-state only bites while the digital side is chosen
  a_oe_analog_driven: assert property (!active_iface && $past(!active_iface) |->
    pixel_data_outputs_oe) else $error("pixel outputs floated in analog mode");
  a_coast_disabled_low: assert property (reg_wr && reg_addr == ADDR_CLAMP_COAST &&
    reg_wdata[3:1] == 3'b011 |-> ##3 coast_out == 1'b0) else $error("coast not disabled");
  a_status_low_zero: assert property (reg_rd && reg_addr == ADDR_SYNC_STATUS |=>
    reg_rdata[2:0] == 3'h0) else $error("status low bits not zero");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h11 || reg_addr > 8'h15) |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  c_coast_seen: cover property (coast_out ##1 !coast_out);
  c_digital_seen: cover property ($rose(active_iface));
  c_tristate_seen: cover property ($fell(pixel_data_outputs_oe));
endmodule
bind ccoc_bank ccoc_bank_sva #(.ACT_WINDOW(ACT_WINDOW)) ccoc_bank_sva_i (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .clamp_mid_green(clamp_mid_green), .clamp_mid_blue(clamp_mid_blue), .coast_out(coast_out),
  .drive_strength(drive_strength), .bw_high(bw_high), .dig_clk_invert(dig_clk_invert),
  .pixel_data_outputs_oe(pixel_data_outputs_oe), .protect_addr(protect_addr), .power_up(power_up),
  .active_iface(active_iface));
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the clamp, coast and output control bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ccoc_pkg::*;
  logic       clock, rst_n, reg_wr, reg_rd, hsync_in, vsync_in;
  logic       green_embedded_sync, dig_clk_in, iface_override, iface_select;
  logic       clamp_mid_green, clamp_mid_blue, coast_out, bw_high, dig_clk_invert;
  logic       pixel_data_outputs_oe, power_up, mode_422, active_iface;
  logic [1:0] drive_strength, protect_addr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] vals [4];
  logic [7:0] out_bits;
  int         err_total, tests_run, cycles;
  ccoc_bank #(.ACT_WINDOW(64)) ccoc_bank_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_in(hsync_in),
    .vsync_in(vsync_in), .green_embedded_sync(green_embedded_sync), .dig_clk_in(dig_clk_in),
    .iface_override(iface_override), .iface_select(iface_select), .clamp_mid_green(clamp_mid_green),
    .clamp_mid_blue(clamp_mid_blue), .coast_out(coast_out), .drive_strength(drive_strength),
    .bw_high(bw_high), .dig_clk_invert(dig_clk_invert), .pixel_data_outputs_oe(pixel_data_outputs_oe),
    .protect_addr(protect_addr), .power_up(power_up), .mode_422(mode_422), .active_iface(active_iface));
  // control outputs laid out like the format register, three-state bit masked
  assign out_bits = {drive_strength, bw_high, dig_clk_invert, 1'b0, protect_addr[0], power_up, mode_422};
  // -------------------------------------------------------------
  // access tasks
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    // idle edge so a following strobe never rises in the step this one falls
    @(posedge clock);
    #1;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    chk(nm, exp, reg_rdata);
    @(posedge clock);
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one sync line: hsync high one cycle, low three
  task automatic sync_line(input logic v);
    hsync_in = 1'b1;
    vsync_in = v;
    tick(1);
    hsync_in = 1'b0;
    vsync_in = 1'b0;
    tick(3);
  endtask
  // ten-line frame; coast sampled after vsync, mid frame, one line before the
  // precoast window opens and on the last line
  task automatic frame(input logic c, input logic post, input logic mid, input logic last);
    for (int i = 0; i < 10; i++) begin
      sync_line(i == 0);
      if (c && i == 0) chk("coast_post", {7'h0, post}, {7'h0, coast_out});
      if (c && i == 5) chk("coast_mid", {7'h0, mid}, {7'h0, coast_out});
      if (c && i == 7) chk("coast_early", {7'h0, mid}, {7'h0, coast_out});
      if (c && i == 9) chk("coast_pre", {7'h0, last}, {7'h0, coast_out});
    end
  endtask
  task automatic pulse(input logic [3:0] m);
    {hsync_in, green_embedded_sync, vsync_in, dig_clk_in} = m;
    tick(1);
    {hsync_in, green_embedded_sync, vsync_in, dig_clk_in} = 4'h0;
    tick(1);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // hang guard well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, hsync_in, vsync_in, green_embedded_sync} = 6'h0;
    {dig_clk_in, iface_override, iface_select} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    tick(3);
    rst_n = 1'b1;
    rd_chk("rst_clamp_coast", ADDR_CLAMP_COAST, 8'h0a);
    rd_chk("rst_precoast", ADDR_PRECOAST, 8'h00);
    rd_chk("rst_postcoast", ADDR_POSTCOAST, 8'h00);
    rd_chk("rst_out_fmt", ADDR_OUT_POWER_FMT, 8'he2);
    chk("rst_outs", 8'he2, out_bits);
    chk("rst_prot_addr", 8'h02, {6'h0, protect_addr});
    $display("test reset_values done");
    vals = '{8'h00, 8'h5d, 8'hb6, 8'he2};
    foreach (vals[i]) begin
      wr(ADDR_OUT_POWER_FMT, vals[i]);
      tick(1);
      chk("out_fmt", vals[i] & 8'hf7, out_bits);
      chk("prot_addr1", 8'h01, {7'h0, protect_addr[1]});
      chk("pdo_oe_analog", 8'h01, {7'h0, pixel_data_outputs_oe});
      rd_chk("reg_out_fmt", ADDR_OUT_POWER_FMT, vals[i]);
    end
    $display("test output_format done");
    vals = '{8'hff, 8'h20, 8'h10, 8'h0a};
    foreach (vals[i]) begin
      wr(ADDR_CLAMP_COAST, vals[i]);
      tick(1);
      chk("clamps", {6'h0, vals[i][5:4]}, {6'h0, clamp_mid_green, clamp_mid_blue});
      rd_chk("reg_clamp_coast", ADDR_CLAMP_COAST, vals[i] & 8'h3e);
    end
    $display("test clamp_select done");
    wr(ADDR_SYNC_STATUS, 8'hff);
    rd_chk("status_ro", ADDR_SYNC_STATUS, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    $display("test read_only done");
    wr(ADDR_PRECOAST, 8'h02);
    wr(ADDR_POSTCOAST, 8'h03);
    rd_chk("precoast", ADDR_PRECOAST, 8'h02);
    rd_chk("postcoast", ADDR_POSTCOAST, 8'h03);
    wr(ADDR_CLAMP_COAST, 8'h0e);
    frame(1'b0, 1'b0, 1'b0, 1'b0);
    frame(1'b1, 1'b1, 1'b0, 1'b1);
    wr(ADDR_CLAMP_COAST, 8'h0c);
    frame(1'b1, 1'b0, 1'b1, 1'b0);
    wr(ADDR_CLAMP_COAST, 8'h08);
    frame(1'b1, 1'b1, 1'b0, 1'b1);
    wr(ADDR_CLAMP_COAST, 8'h06);
    frame(1'b1, 1'b0, 1'b0, 1'b0);
    $display("test coast_window done");
    tick(80);
    rd_chk("status_idle", ADDR_SYNC_STATUS, 8'h00);
    pulse(4'hf);
    rd_chk("status_all", ADDR_SYNC_STATUS, 8'hf0);
    iface_override = 1'b1;
    iface_select = 1'b1;
    tick(2);
    rd_chk("status_user", ADDR_SYNC_STATUS, 8'hf8);
    chk("active_iface", 8'h01, {7'h0, active_iface});
    wr(ADDR_OUT_POWER_FMT, 8'hea);
    tick(1);
    chk("pdo_oe_digital", 8'h00, {7'h0, pixel_data_outputs_oe});
    iface_override = 1'b0;
    iface_select = 1'b0;
    tick(80);
    pulse(4'h1);
    rd_chk("status_dig", ADDR_SYNC_STATUS, 8'h18);
    $display("test sync_activity done");
    complete_run();
  end
endmodule
`default_nettype wire
